// ==== rtl/mhr_pkg.sv ====
// Shared constants and types of the half-register multiply-accumulate datapath.
package mhr_pkg;

   localparam int OPND_W = 16;
   localparam int ACC_W = 40;
   localparam int WIDE_W = 44;
   localparam int REG_ADDR_W = 3;
   localparam int REG_DATA_W = 32;
   localparam int ROUND_BIT = 16;

   // Word offsets on the register port.
   localparam logic [2:0] OFS_STATUS = 3'h0;
   localparam logic [2:0] OFS_ACC0_LO = 3'h1;
   localparam logic [2:0] OFS_ACC0_EXT = 3'h2;
   localparam logic [2:0] OFS_ACC1_LO = 3'h3;
   localparam logic [2:0] OFS_ACC1_EXT = 3'h4;

   // Field positions of arith_status_reg.
   localparam int BIT_RND = 0;
   localparam int BIT_V = 1;
   localparam int BIT_VS = 2;
   localparam int BIT_AV0 = 3;
   localparam int BIT_AV0S = 4;
   localparam int BIT_AV1 = 5;
   localparam int BIT_ACC_ONE_SAT_STICKY = 6;

   localparam logic RND_RESET = 1'b0;

   localparam logic [15:0] MOST_NEG_HALF = 16'h8000;
   localparam logic [31:0] FRAC_PROD_MAX = 32'h7FFF_FFFF;

   // Accumulator limits, held sign-extended at the working width.
   localparam logic signed [43:0] S40_MAX = 44'h07F_FFFF_FFFF;
   localparam logic signed [43:0] S40_MIN = 44'hF80_0000_0000;
   localparam logic signed [43:0] U40_MAX = 44'h0FF_FFFF_FFFF;
   localparam logic signed [43:0] U40_MIN = 44'h000_0000_0000;
   localparam logic signed [43:0] S32_MAX = 44'h000_7FFF_FFFF;
   localparam logic signed [43:0] S32_MIN = 44'hFFF_8000_0000;

   // Half-register limits and the rounding increment.
   localparam logic signed [43:0] S16_MAX = 44'h000_0000_7FFF;
   localparam logic signed [43:0] S16_MIN = 44'hFFF_FFFF_8000;
   localparam logic signed [43:0] U16_MAX = 44'h000_0000_FFFF;
   localparam logic signed [43:0] ROUND_HALF = 44'h000_0000_8000;
   localparam logic [15:0] TIE_PATTERN = 16'h8000;

   typedef enum logic [3:0] {
      MODE_SIGNED_FRAC,
      MODE_UNSIGNED_FRACTION,
      MODE_SIGNED_INTEGER,
      MODE_UNSIGNED_INTEGER,
      MODE_SIGNED_FRAC_CHOP,
      MODE_UNSIGNED_FRAC_CHOP,
      MODE_SCALED_FRACTION_ROUND,
      MODE_SCALED_SIGNED_INTEGER,
      MODE_INTEGER_HIGH_WORD
   } mhr_mode_t;

   typedef enum logic [1:0] {
      ACC_LOAD,
      ACC_ADD,
      ACC_SUB
   } mhr_acc_op_t;

endpackage

// ==== rtl/mhr_product.sv ====
// Product former: operand signedness, shift correction and extension.
`timescale 1ns/1ps
module mhr_product
(
   input wire logic [15:0] src0, // First operand.
   input wire logic [15:0] src1, // Second operand.
   input wire logic uns, // Unsigned operand format.
   input wire logic frac_sh, // Signed fraction format with shift correction.
   input wire logic mixed, // Signed first operand by unsigned second.
   output logic signed [43:0] prod // Product extended to the working width.
);

   logic sgn0;
   logic sgn1;
   logic signed [16:0] ext0;
   logic signed [16:0] ext1;
   logic signed [33:0] raw;

   always_comb
   begin
      sgn0 = !uns || mixed;
      sgn1 = !uns && !mixed;
      ext0 = {sgn0 & src0[15], src0};
      ext1 = {sgn1 & src1[15], src1};
      raw = ext0 * ext1;
      if (frac_sh && !mixed && src0 == mhr_pkg::MOST_NEG_HALF
          && src1 == mhr_pkg::MOST_NEG_HALF)
      begin
         prod = {12'h000, mhr_pkg::FRAC_PROD_MAX};
      end
      else if (frac_sh && !mixed)
      begin
         prod = {{9{raw[33]}}, raw, 1'b0};
      end
      else
      begin
         prod = {{10{raw[33]}}, raw};
      end
   end

endmodule

// ==== rtl/mhr_mac_half.sv ====
// Dual multiply-accumulate datapath writing saturated half-register results.
//
// Behaviour
// - Each unit multiplies two 16-bit halves, then loads, adds or subtracts.
// - The updated accumulator yields a saturated 16-bit half-register result.
// - Unit zero uses accumulator zero, low half; unit one accumulator one, high.
// - The rounding select bit picks biased or unbiased rounding when extracting.
// - Default format multiplies signed 1.15 values, left shift gives 1.31.
// - Minus one squared in signed fraction saturates to largest 1.31 value.
// - Signed fraction products sign-extend to 9.31, accumulator saturates there.
// - Default extraction rounds at bit 16, saturates to 1.15.
// - Unsigned fraction: no shift, zero-extend to 8.32, unsigned accumulator saturation.
// - Unsigned fraction extraction rounds at bit 16, saturates to 0.16.
// - Signed integer: no shift, sign-extend to 40.0, signed 40-bit saturation.
// - Signed integer extraction saturates the accumulator to signed 16 bits.
// - Unsigned integer: zero-extend, accumulator floor zero, unsigned 16-bit extraction.
// - Signed fraction chop mode truncates at bit 16 instead of rounding.
// - Unsigned fraction chop mode truncates at bit 16 instead of rounding.
// - Scaled fraction mode doubles, rounds at bit 16, saturates to 1.15.
// - Scaled integer mode doubles the accumulator, saturates to signed 16.
// - High-word mode saturates to 32 bits, rounds, saturates, takes top half.
// - Mixed mode on unit one: signed by unsigned, no shift correction.
// - Truncation drops low bits that do not fit the half.
// - Saturation is applied after rounding.
// - Extraction leaves the accumulator unchanged.
// - Result saturation flag tracks each extraction; extractions only set its sticky copy, software clears it.
// - Each accumulator has a saturation flag and a sticky companion.
`timescale 1ns/1ps
module mhr_mac_half
(
   input wire logic CLK, // Core clock, 20 MHz.
   input wire logic RST_B, // Asynchronous reset, active low.
   input wire logic OP_VALID, // Operation request, one cycle.
   input wire logic OP_UNIT, // Zero selects unit zero, one selects unit one.
   input wire logic [1:0] OP_ACC, // Load, add or subtract.
   input wire logic [3:0] OP_MODE, // Format option.
   input wire logic OP_MIXED, // Mixed signedness, honoured on unit one only.
   input wire logic [15:0] OP_SRC0, // First source half-word.
   input wire logic [15:0] OP_SRC1, // Second source half-word.
   input wire logic [2:0] REG_ADDR, // Register word offset.
   input wire logic [31:0] REG_WDATA, // Register write data.
   input wire logic REG_WR, // Register write strobe.
   input wire logic REG_RD, // Register read strobe.
   output logic [31:0] REG_RDATA, // Read data, in the cycle after the strobe.
   output logic RES_VALID, // Half-register result pulse.
   output logic RES_HIGH, // Result goes to the upper half.
   output logic [15:0] RES_DATA, // Extracted half-register value.
   output logic ROUNDING_SELECT_BIT, // One selects biased rounding.
   output logic HALF_RESULT_SAT, // Last extraction saturated.
   output logic HALF_RESULT_SAT_STICKY, // Sticky copy of the above.
   output logic ACC_ZERO_SAT_FLAG, // Accumulator zero saturated on its last update.
   output logic ACC_ZERO_SAT_STICKY, // Sticky copy for accumulator zero.
   output logic ACC_ONE_SAT_FLAG, // Accumulator one saturated on its last update.
   output logic ACC_ONE_SAT_STICKY // Sticky copy for accumulator one.
);

   typedef struct packed {
      logic rnd;
      logic v;
      logic vs;
      logic av0;
      logic av0s;
      logic av1;
      logic acc_one_sat_sticky;
      logic [39:0] acc0;
      logic [39:0] acc1;
      logic res_valid;
      logic res_high;
      logic [15:0] res_data;
      logic [31:0] rdata;
   } mhr_state_t;

   mhr_state_t st_reg;
   mhr_state_t st_next;

   mhr_pkg::mhr_mode_t mode;
   mhr_pkg::mhr_acc_op_t acc_op;
   logic uns;
   logic frac_sh;
   logic wide;
   logic rounds;
   logic scale;
   logic hi32;
   logic mixed;
   logic signed [43:0] prod;
   logic [39:0] acc_cur;
   logic signed [43:0] acc_ext;
   logic signed [43:0] sum;
   logic signed [43:0] acc_lo;
   logic signed [43:0] acc_hi;
   logic signed [43:0] acc_new;
   logic acc_sat;
   logic signed [43:0] scaled;
   logic signed [43:0] rnd_sum;
   logic signed [43:0] quot;
   logic signed [43:0] half_lo;
   logic signed [43:0] half_hi;
   logic [15:0] half_val;
   logic half_sat;
   logic [31:0] rd_val;

   // Decoding the format option into the few controls the datapath needs.
   always_comb
   begin
      mode = mhr_pkg::mhr_mode_t'(OP_MODE);
      acc_op = mhr_pkg::mhr_acc_op_t'(OP_ACC);
      uns = 1'b0;
      frac_sh = 1'b1;
      wide = 1'b1;
      rounds = 1'b1;
      scale = 1'b0;
      hi32 = 1'b0;
      case (mode)
         mhr_pkg::MODE_UNSIGNED_FRACTION:
         begin
            uns = 1'b1;
            frac_sh = 1'b0;
         end
         mhr_pkg::MODE_UNSIGNED_FRAC_CHOP:
         begin
            uns = 1'b1;
            frac_sh = 1'b0;
            rounds = 1'b0;
         end
         mhr_pkg::MODE_SIGNED_INTEGER:
         begin
            frac_sh = 1'b0;
            wide = 1'b0;
            rounds = 1'b0;
         end
         mhr_pkg::MODE_UNSIGNED_INTEGER:
         begin
            uns = 1'b1;
            frac_sh = 1'b0;
            wide = 1'b0;
            rounds = 1'b0;
         end
         mhr_pkg::MODE_SIGNED_FRAC_CHOP:
         begin
            rounds = 1'b0;
         end
         mhr_pkg::MODE_SCALED_FRACTION_ROUND:
         begin
            scale = 1'b1;
         end
         mhr_pkg::MODE_SCALED_SIGNED_INTEGER:
         begin
            frac_sh = 1'b0;
            wide = 1'b0;
            rounds = 1'b0;
            scale = 1'b1;
         end
         mhr_pkg::MODE_INTEGER_HIGH_WORD:
         begin
            frac_sh = 1'b0;
            hi32 = 1'b1;
         end
         default: uns = 1'b0;
      endcase
      mixed = OP_MIXED && OP_UNIT;
   end

   mhr_product u_product
   (
      .src0(OP_SRC0),
      .src1(OP_SRC1),
      .uns(uns),
      .frac_sh(frac_sh),
      .mixed(mixed),
      .prod(prod)
   );

   // Accumulate, saturate the accumulator, then extract from the new value.
   always_comb
   begin
      acc_cur = OP_UNIT ? st_reg.acc1 : st_reg.acc0;
      acc_ext = uns ? {4'h0, acc_cur} : {{4{acc_cur[39]}}, acc_cur};
      case (acc_op)
         mhr_pkg::ACC_ADD: sum = acc_ext + prod;
         mhr_pkg::ACC_SUB: sum = acc_ext - prod;
         default: sum = prod;
      endcase
      acc_lo = hi32 ? mhr_pkg::S32_MIN : (uns ? mhr_pkg::U40_MIN : mhr_pkg::S40_MIN);
      acc_hi = hi32 ? mhr_pkg::S32_MAX : (uns ? mhr_pkg::U40_MAX : mhr_pkg::S40_MAX);
      acc_sat = (sum < acc_lo) || (sum > acc_hi);
      acc_new = (sum < acc_lo) ? acc_lo : ((sum > acc_hi) ? acc_hi : sum);
      scaled = scale ? (acc_new <<< 1) : acc_new;
      rnd_sum = scaled + mhr_pkg::ROUND_HALF;
      if (!wide)
      begin
         quot = scaled;
      end
      else if (!rounds)
      begin
         quot = scaled >>> mhr_pkg::ROUND_BIT;
      end
      else
      begin
         quot = rnd_sum >>> mhr_pkg::ROUND_BIT;
         if (!st_reg.rnd && scaled[15:0] == mhr_pkg::TIE_PATTERN)
         begin
            quot[0] = 1'b0;
         end
      end
      half_lo = uns ? mhr_pkg::U40_MIN : mhr_pkg::S16_MIN;
      half_hi = uns ? mhr_pkg::U16_MAX : mhr_pkg::S16_MAX;
      half_sat = (quot < half_lo) || (quot > half_hi);
      half_val = (quot < half_lo) ? half_lo[15:0] : ((quot > half_hi) ? half_hi[15:0] : quot[15:0]);
   end

   // Register read mux; unmapped offsets read as zero.
   always_comb
   begin
      rd_val = '0;
      case (REG_ADDR)
         mhr_pkg::OFS_STATUS:
         begin
            rd_val[mhr_pkg::BIT_RND] = st_reg.rnd;
            rd_val[mhr_pkg::BIT_V] = st_reg.v;
            rd_val[mhr_pkg::BIT_VS] = st_reg.vs;
            rd_val[mhr_pkg::BIT_AV0] = st_reg.av0;
            rd_val[mhr_pkg::BIT_AV0S] = st_reg.av0s;
            rd_val[mhr_pkg::BIT_AV1] = st_reg.av1;
            rd_val[mhr_pkg::BIT_ACC_ONE_SAT_STICKY] = st_reg.acc_one_sat_sticky;
         end
         mhr_pkg::OFS_ACC0_LO: rd_val = st_reg.acc0[31:0];
         mhr_pkg::OFS_ACC0_EXT: rd_val[7:0] = st_reg.acc0[39:32];
         mhr_pkg::OFS_ACC1_LO: rd_val = st_reg.acc1[31:0];
         mhr_pkg::OFS_ACC1_EXT: rd_val[7:0] = st_reg.acc1[39:32];
         default: rd_val = '0;
      endcase
   end

   // Next state: software clears first so that a hardware set in the same cycle wins.
   always_comb
   begin
      st_next = st_reg;
      st_next.res_valid = 1'b0;
      st_next.rdata = REG_RD ? rd_val : '0;
      if (REG_WR && REG_ADDR == mhr_pkg::OFS_STATUS)
      begin
         st_next.rnd = REG_WDATA[mhr_pkg::BIT_RND];
         st_next.vs = st_reg.vs & ~REG_WDATA[mhr_pkg::BIT_VS];
         st_next.av0s = st_reg.av0s & ~REG_WDATA[mhr_pkg::BIT_AV0S];
         st_next.acc_one_sat_sticky = st_reg.acc_one_sat_sticky & ~REG_WDATA[mhr_pkg::BIT_ACC_ONE_SAT_STICKY];
      end
      if (OP_VALID)
      begin
         st_next.res_valid = 1'b1;
         st_next.res_high = OP_UNIT;
         st_next.res_data = half_val;
         st_next.v = half_sat;
         st_next.vs = st_next.vs | half_sat;
         if (OP_UNIT)
         begin
            st_next.acc1 = acc_new[39:0];
            st_next.av1 = acc_sat;
            st_next.acc_one_sat_sticky = st_next.acc_one_sat_sticky | acc_sat;
         end
         else
         begin
            st_next.acc0 = acc_new[39:0];
            st_next.av0 = acc_sat;
            st_next.av0s = st_next.av0s | acc_sat;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_reg <= '{rnd: mhr_pkg::RND_RESET, default: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign REG_RDATA = st_reg.rdata;
   assign RES_VALID = st_reg.res_valid;
   assign RES_HIGH = st_reg.res_high;
   assign RES_DATA = st_reg.res_data;
   assign ROUNDING_SELECT_BIT = st_reg.rnd;
   assign HALF_RESULT_SAT = st_reg.v;
   assign HALF_RESULT_SAT_STICKY = st_reg.vs;
   assign ACC_ZERO_SAT_FLAG = st_reg.av0;
   assign ACC_ZERO_SAT_STICKY = st_reg.av0s;
   assign ACC_ONE_SAT_FLAG = st_reg.av1;
   assign ACC_ONE_SAT_STICKY = st_reg.acc_one_sat_sticky;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   sequence op0_load_s;
      OP_VALID && !OP_UNIT && (acc_op == mhr_pkg::ACC_LOAD);
   endsequence

   sequence idle_two_s;
      !OP_VALID [*2];
   endsequence

   res_pulse_a: assert property (OP_VALID |=> RES_VALID)
      else $error("Result pulse missing after request.");
   half_select_a: assert property (OP_VALID |=> RES_HIGH == $past(OP_UNIT))
      else $error("Result sent to the wrong half.");
   acc_isolate_a: assert property (OP_VALID && !OP_UNIT |=> $stable(st_reg.acc1))
      else $error("Unit zero disturbed accumulator one.");
   acc_hold_a: assert property (idle_two_s |-> $stable(st_reg.acc0) && $stable(st_reg.acc1))
      else $error("Accumulator changed without an operation.");
   neg_square_a: assert property (
      op0_load_s ##0 (mode == mhr_pkg::MODE_SIGNED_FRAC && OP_SRC0 == mhr_pkg::MOST_NEG_HALF
         && OP_SRC1 == mhr_pkg::MOST_NEG_HALF)
      |=> st_reg.acc0 == {8'h00, mhr_pkg::FRAC_PROD_MAX} && RES_DATA == 16'h7FFF)
      else $error("Most negative square not saturated.");
   tie_biased_a: assert property (
      op0_load_s ##0 (mode == mhr_pkg::MODE_SIGNED_FRAC && OP_SRC0 == 16'h4000
         && OP_SRC1 == 16'h0001 && st_reg.rnd)
      |=> RES_DATA == 16'h0001 && !HALF_RESULT_SAT)
      else $error("Biased tie did not round up.");
   tie_unbiased_a: assert property (
      op0_load_s ##0 (mode == mhr_pkg::MODE_SIGNED_FRAC && OP_SRC0 == 16'h4000
         && OP_SRC1 == 16'h0001 && !st_reg.rnd)
      |=> RES_DATA == 16'h0000)
      else $error("Unbiased tie did not round to even.");
   unsigned_ext_a: assert property (
      op0_load_s ##0 (mode == mhr_pkg::MODE_UNSIGNED_FRACTION)
      |=> st_reg.acc0[39:32] == 8'h00 && !ACC_ZERO_SAT_FLAG)
      else $error("Unsigned product not zero extended.");
   int_half_sat_a: assert property (
      op0_load_s ##0 (mode == mhr_pkg::MODE_SIGNED_INTEGER && OP_SRC0 == 16'h7FFF
         && OP_SRC1 == 16'h7FFF)
      |=> RES_DATA == 16'h7FFF && HALF_RESULT_SAT && HALF_RESULT_SAT_STICKY)
      else $error("Integer extraction did not saturate.");
   // sticky follows flag
   // A software clear may leave a sticky low under a raised flag, so only fresh updates count.
   acc_sticky_a: assert property (
      (RES_VALID && !RES_HIGH && ACC_ZERO_SAT_FLAG |-> ACC_ZERO_SAT_STICKY)
      and (RES_VALID && RES_HIGH && ACC_ONE_SAT_FLAG |-> ACC_ONE_SAT_STICKY))
      else $error("Accumulator sticky flag not set.");

endmodule

// ==== sim/mhr_dreg_model.sv ====
// Model of the data register that takes the half-register results.
`timescale 1ns/1ps
module mhr_dreg_model
(
   input wire logic clk, // Core clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic res_valid, // Result pulse.
   input wire logic res_high, // Upper half selected.
   input wire logic [15:0] res_data, // Result half-word.
   output logic [31:0] dreg // Destination data register.
);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dreg <= 32'h0000_0000;
      end
      else if (res_valid && res_high)
      begin
         dreg[31:16] <= res_data;
      end
      else if (res_valid)
      begin
         dreg[15:0] <= res_data;
      end
   end
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench of the half-register multiply-accumulate datapath.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("BAD %s expected %h seen %h", nm, exp, got); \
      end \
   end
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic op_valid = 1'b0;
   logic op_unit = 1'b0;
   logic [1:0] op_acc = 2'h0;
   logic [3:0] op_mode = 4'h0;
   logic op_mixed = 1'b0;
   logic [15:0] op_src0 = 16'h0000;
   logic [15:0] op_src1 = 16'h0000;
   logic [2:0] reg_addr = 3'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] dreg;
   logic [15:0] res_data;
   logic res_valid, res_high, rnd_sel, hsat, hsat_s, a0_sat, a0_sat_s, a1_sat, a1_sat_s;
   int num_errors = 0;
   int n_compared = 0;

   always #25 clk = ~clk;

   mhr_mac_half i_dut
   (
      .CLK(clk), .RST_B(rst_b), .OP_VALID(op_valid), .OP_UNIT(op_unit), .OP_ACC(op_acc),
      .OP_MODE(op_mode), .OP_MIXED(op_mixed), .OP_SRC0(op_src0), .OP_SRC1(op_src1),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .RES_VALID(res_valid), .RES_HIGH(res_high),
      .RES_DATA(res_data), .ROUNDING_SELECT_BIT(rnd_sel), .HALF_RESULT_SAT(hsat),
      .HALF_RESULT_SAT_STICKY(hsat_s), .ACC_ZERO_SAT_FLAG(a0_sat),
      .ACC_ZERO_SAT_STICKY(a0_sat_s), .ACC_ONE_SAT_FLAG(a1_sat),
      .ACC_ONE_SAT_STICKY(a1_sat_s)
   );

   mhr_dreg_model i_dreg
   (
      .clk(clk), .rst_b(rst_b), .res_valid(res_valid), .res_high(res_high),
      .res_data(res_data), .dreg(dreg)
   );

   task automatic wrap_up();
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
      begin
         $display("Test passed");
      end
      else
      begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_check(input logic [2:0] a, input logic [31:0] exp);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", exp, reg_rdata)
   endtask

   task automatic drive_op(input logic u, input logic [1:0] a, input logic [3:0] m,
      input logic mx, input logic [15:0] s0, input logic [15:0] s1);
      {op_valid, op_unit, op_acc, op_mode, op_mixed, op_src0, op_src1} <= {1'b1, u, a, m, mx, s0, s1};
   endtask

   // The result is looked at in its only valid cycle, the register half one cycle later.
   task automatic run_op(input logic u, input logic [1:0] a, input logic [3:0] m,
      input logic mx, input logic [15:0] s0, input logic [15:0] s1,
      input logic [15:0] d, input logic v, input logic av);
      @(posedge clk);
      drive_op(u, a, m, mx, s0, s1);
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      `CHK("res_valid", 1'b1, res_valid)
      `CHK("res_high", u, res_high)
      `CHK("res_data", d, res_data)
      `CHK("half_sat", v, hsat)
      `CHK("acc_sat", av, u ? a1_sat : a0_sat)
      @(posedge clk);
      #1;
      `CHK("res_valid_end", 1'b0, res_valid)
      `CHK("dreg_half", d, u ? dreg[31:16] : dreg[15:0])
   endtask

   task automatic t_formats();
      run_op(1'b0, 2'h0, 4'h0, 1'b0, 16'h4000, 16'h4000, 16'h2000, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h0, 1'b0, 16'h8000, 16'h8000, 16'h7FFF, 1'b1, 1'b0);
      run_op(1'b0, 2'h1, 4'h0, 1'b0, 16'h8000, 16'h8000, 16'h7FFF, 1'b1, 1'b0);
      reg_check(3'h1, 32'hFFFF_FFFE);
      reg_check(3'h2, 32'h0000_0000);
      run_op(1'b0, 2'h0, 4'h4, 1'b0, 16'hFFFF, 16'h0001, 16'hFFFF, 1'b0, 1'b0);
      reg_check(3'h2, 32'h0000_00FF);
      run_op(1'b1, 2'h0, 4'h0, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h1, 1'b0, 16'h8000, 16'h8000, 16'h4000, 1'b0, 1'b0);
      run_op(1'b1, 2'h0, 4'h6, 1'b0, 16'h4000, 16'h4000, 16'h4000, 1'b0, 1'b0);
      run_op(1'b1, 2'h0, 4'h7, 1'b0, 16'h4000, 16'h0001, 16'h7FFF, 1'b1, 1'b0);
      run_op(1'b1, 2'h0, 4'h8, 1'b0, 16'h7FFF, 16'h7FFF, 16'h3FFF, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h3, 1'b0, 16'h0100, 16'h0100, 16'hFFFF, 1'b1, 1'b0);
      run_op(1'b0, 2'h0, 4'h2, 1'b0, 16'h7FFF, 16'h7FFF, 16'h7FFF, 1'b1, 1'b0);
      run_op(1'b0, 2'h0, 4'h2, 1'b0, 16'h0005, 16'h0007, 16'h0023, 1'b0, 1'b0);
      run_op(1'b0, 2'h2, 4'h2, 1'b0, 16'h0002, 16'h0003, 16'h001D, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h2, 1'b1, 16'h0003, 16'hFFFE, 16'hFFFA, 1'b0, 1'b0);
      run_op(1'b1, 2'h0, 4'h2, 1'b1, 16'h0003, 16'hFFFE, 16'h7FFF, 1'b1, 1'b0);
      run_op(1'b0, 2'h0, 4'h3, 1'b0, 16'h0001, 16'h0001, 16'h0001, 1'b0, 1'b0);
      run_op(1'b0, 2'h2, 4'h3, 1'b0, 16'h0002, 16'h0001, 16'h0000, 1'b0, 1'b1);
   endtask

   task automatic t_sticky();
      reg_check(3'h0, 32'h0000_001C);
      reg_write(3'h0, 32'h0000_0054);
      reg_check(3'h0, 32'h0000_0008);
      `CHK("half_sticky", 1'b0, hsat_s)
      `CHK("acc0_sticky", 1'b0, a0_sat_s)
      `CHK("acc0_flag", 1'b1, a0_sat)
   endtask

   // Back-to-back adds of the largest integer product reach the 40-bit ceiling on the last one.
   task automatic t_acc_one_sat();
      @(posedge clk);
      drive_op(1'b1, 2'h0, 4'h2, 1'b0, 16'h8000, 16'h8000);
      @(posedge clk);
      op_acc <= 2'h1;
      repeat (510) @(posedge clk);
      #1;
      `CHK("acc1_sat_early", 1'b0, a1_sat)
      `CHK("res_valid_run", 1'b1, res_valid)
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      `CHK("acc1_sat", 1'b1, a1_sat)
      `CHK("acc1_sticky", 1'b1, a1_sat_s)
      `CHK("res_sat", 16'h7FFF, res_data)
      reg_check(3'h3, 32'hFFFF_FFFF);
      reg_check(3'h4, 32'h0000_007F);
      `CHK("dreg_high", 16'h7FFF, dreg[31:16])
      run_op(1'b1, 2'h0, 4'h2, 1'b0, 16'h0003, 16'hFFFE, 16'hFFFA, 1'b0, 1'b0);
      `CHK("acc1_sticky_kept", 1'b1, a1_sat_s)
      reg_check(3'h0, 32'h0000_004C);
   endtask

   task automatic t_rounding();
      run_op(1'b0, 2'h0, 4'h1, 1'b0, 16'h0001, 16'h8000, 16'h0000, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h5, 1'b0, 16'h0001, 16'h8000, 16'h0000, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h0, 1'b0, 16'h4000, 16'h0001, 16'h0000, 1'b0, 1'b0);
      reg_write(3'h0, 32'h0000_0001);
      #1;
      `CHK("rnd_sel", 1'b1, rnd_sel)
      run_op(1'b0, 2'h0, 4'h1, 1'b0, 16'h0001, 16'h8000, 16'h0001, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h5, 1'b0, 16'h0001, 16'h8000, 16'h0000, 1'b0, 1'b0);
      run_op(1'b0, 2'h0, 4'h0, 1'b0, 16'h4000, 16'h0001, 16'h0001, 1'b0, 1'b0);
      reg_write(3'h0, 32'h0000_0000);
   endtask

   task automatic t_reg_refuse();
      reg_write(3'h1, 32'hFFFF_FFFF);
      reg_check(3'h1, 32'h0000_8000);
      reg_check(3'h5, 32'h0000_0000);
      reg_check(3'h0, 32'h0000_0044);
   endtask

   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      $display("BAD watchdog expected finish seen timeout");
      wrap_up();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      `CHK("rnd_reset", 1'b0, rnd_sel)
      reg_check(3'h0, 32'h0000_0000);
      t_formats();
      t_sticky();
      t_acc_one_sat();
      t_rounding();
      t_reg_refuse();
      wrap_up();
   end
endmodule
